// file: hw/rsk_alu_regs.vh
// opcode encodings, flag positions, reset values and timing counts
`ifndef RSK_ALU_REGS_VH
`define RSK_ALU_REGS_VH

// ========================================
// operation codes
`define OP_NONE                         5'h00
`define OP_ROTATE_LEFT_TO_WORK          5'h01
`define OP_ROTATE_LEFT_THROUGH_BIT      5'h02
`define OP_ROTATE_LEFT_THROUGH_BIT_WORK 5'h03
`define OP_ROTATE_RIGHT_IN_PLACE        5'h04
`define OP_ROTATE_RIGHT_TO_WORK         5'h05
`define OP_ROTATE_RIGHT_THROUGH_BIT     5'h06
`define OP_ROTATE_RIGHT_THROUGH_BIT_WORK 5'h07
`define OP_MINUS_WITH_BORROW_TO_WORK    5'h08
`define OP_MINUS_WITH_BORROW_TO_MEMORY  5'h09
`define OP_MINUS_TO_WORK                5'h0a
`define OP_MINUS_TO_MEMORY              5'h0b
`define OP_MINUS_IMMEDIATE              5'h0c
`define OP_DEC_SKIP_ON_NULL             5'h0d
`define OP_DEC_SKIP_ON_NULL_TO_WORK     5'h0e
`define OP_INC_SKIP_ON_NULL             5'h0f
`define OP_INC_SKIP_ON_NULL_TO_WORK     5'h10
`define OP_BIT_SKIP_IF_ONE              5'h11
`define OP_BYTE_SET                     5'h12
`define OP_BIT_SET                      5'h13
`define OP_NIBBLE_EXCHANGE              5'h14
`define OP_NIBBLE_EXCHANGE_TO_WORK      5'h15

// ========================================
// flag bit positions in flags vector
`define FLAG_CARRY_BIT                  0
`define FLAG_HALF_BORROW_BIT            1
`define FLAG_ZERO_BIT                   2
`define FLAG_SIGN_WRAP_BIT              3

// ========================================
// reset values and constants
`define WORK_RESET                      8'h00
`define FLAGS_RESET                     4'h0
`define BYTE_ALL_ONES                   8'hff
`define BYTE_ONE                        8'h01

// ========================================
// timing: cycles of a taken skip's dummy slot
`define SKIP_DUMMY_CYCLES               1

`endif

// file: hw/rsk_sub_unit.v
// eight-bit subtractor with carry-as-inverted-borrow flags
`timescale 1ns/1ps
`default_nettype none

module rsk_sub_unit (
    // operands
    input  wire [7:0] minuend_i,
    input  wire [7:0] subtrahend_i,
    input  wire       carry_in_i,
    // results
    output wire [7:0] diff_o,
    output wire       carry_o,
    output wire       half_borrow_flag_o,
    output wire       zero_o,
    output wire       sign_wrap_flag_o
);

    wire [8:0] full_sum;
    wire [4:0] low_sum;

    // ========================================
    // add the inverted subtrahend so carry out means no borrow
    // [RULE9] carry is inverted borrow
    assign full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {8'h00, carry_in_i};
    // [RULE23] half-borrow from low nibble
    assign low_sum  = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]}
                      + {4'h0, carry_in_i};

    assign diff_o             = full_sum[7:0];
    assign carry_o            = full_sum[8];
    assign half_borrow_flag_o = low_sum[4];
    // [RULE23] zero on 8-bit result
    assign zero_o             = (full_sum[7:0] == 8'h00);
    // [RULE23] signed wrap detection
    assign sign_wrap_flag_o   = (minuend_i[7] ^ subtrahend_i[7]) & (minuend_i[7] ^ full_sum[7]);

endmodule // rsk_sub_unit

`default_nettype wire

// file: hw/rotate_subtract_skip_alu.v
// execution unit for rotate, subtract, skip, set and swap operations
//
// What this block does
// [RULE1] rotate left to work: mem bit i to work bit i+1, bit7 to bit0
// [RULE2] rotate left through carry in place; only carry changes
// [RULE3] rotate left through carry into work; memory unchanged, carry from bit7
// [RULE4] rotate right in place; bit0 wraps to bit7; no flags
// [RULE5] rotate right into work; bit0 wraps to bit7; nothing else changes
// [RULE6] rotate right through carry in place; only carry changes
// [RULE7] rotate right through carry into work; carry from bit0
// [RULE8] work minus memory minus inverted carry to work or memory, four flags
// [RULE9] subtraction carry is clear on negative result, set otherwise
// [RULE10] work minus memory into work, four flags updated
// [RULE11] work minus memory written back to memory, four flags updated
// [RULE12] work minus immediate into work, four flags updated
// [RULE13] decrement memory in place, skip next when zero, no flags
// [RULE14] memory minus one into work, skip when zero, no flags
// [RULE15] a taken skip adds one dummy cycle
// [RULE16] increment memory in place, skip next when zero, no flags
// [RULE17] memory plus one into work, skip when zero
// [RULE18] skip next when selected memory bit is one, no flags
// [RULE19] write all ones to memory byte, no flags
// [RULE20] set only selected memory bit, no flags
// [RULE21] swap memory nibbles in place, no flags
// [RULE22] swap memory nibbles into work, memory unchanged
// [RULE23] zero on 8-bit result; signed overflow; low-nibble half borrow
`timescale 1ns/1ps
`default_nettype none
`include "rsk_alu_regs.vh"

module rotate_subtract_skip_alu (
    // clock and reset
    input  wire       core_clk_i,
    input  wire       reset_n_i,
    // instruction issue
    input  wire       op_valid_i,
    input  wire [4:0] op_code_i,
    input  wire [2:0] bit_sel_i,
    input  wire [7:0] immediate_i,
    output wire       op_ready_o,
    // data memory operand
    input  wire [7:0] mem_rdata_i,
    output reg  [7:0] mem_wdata_o,
    output reg        mem_we_o,
    // architectural state
    output wire [7:0] work_register_o,
    output wire       carry_flag_o,
    output wire       half_borrow_flag_o,
    output wire       zero_flag_o,
    output wire       sign_wrap_flag_o,
    // skip signalling
    output reg        skip_taken_o,
    output wire       dummy_cycle_o
);

    // ========================================
    // state
    localparam ST_RUN   = 1'b0;
    localparam ST_DUMMY = 1'b1;

    reg        state_ff;
    reg        nxt_state;
    reg  [7:0] work_register_ff;
    reg  [7:0] nxt_work_register;
    reg  [3:0] flags_ff;
    reg  [3:0] nxt_flags;
    reg  [7:0] nxt_mem_wdata;
    reg        nxt_mem_we;
    reg        nxt_skip;

    wire       issue;
    wire       carry_now;
    wire [7:0] sub_rhs;
    wire       sub_cin;
    wire [7:0] sub_diff;
    wire       sub_carry;
    wire       sub_half;
    wire       sub_zero;
    wire       sub_wrap;
    wire [7:0] mem_dec;
    wire [7:0] mem_inc;

    // ========================================
    // helpers
    function [7:0] bit_mask;
        input [2:0] sel;
        begin
            bit_mask = `BYTE_ONE << sel;
        end
    endfunction

    function [3:0] sub_flags;
        input c;
        input h;
        input z;
        input v;
        begin
            sub_flags = 4'h0;
            sub_flags[`FLAG_CARRY_BIT]       = c;
            sub_flags[`FLAG_HALF_BORROW_BIT] = h;
            sub_flags[`FLAG_ZERO_BIT]        = z;
            sub_flags[`FLAG_SIGN_WRAP_BIT]   = v;
        end
    endfunction

    // one shifter per direction, so plain and through-carry rotates agree
    function [7:0] shift_left_fill;
        input [7:0] value;
        input       fill;
        begin
            shift_left_fill = {value[6:0], fill};
        end
    endfunction

    function [7:0] shift_right_fill;
        input [7:0] value;
        input       fill;
        begin
            shift_right_fill = {fill, value[7:1]};
        end
    endfunction

    function [7:0] swap_nibbles;
        input [7:0] value;
        begin
            swap_nibbles = {value[3:0], value[7:4]};
        end
    endfunction

    function byte_is_null;
        input [7:0] value;
        begin
            byte_is_null = (value == 8'h00);
        end
    endfunction

    // issue blocked while the skip's dummy slot runs
    assign op_ready_o = (state_ff == ST_RUN);
    assign issue      = op_valid_i & op_ready_o;
    assign carry_now  = flags_ff[`FLAG_CARRY_BIT];

    // ========================================
    // subtractor operand select
    // [RULE12] immediate operand
    assign sub_rhs = (op_code_i == `OP_MINUS_IMMEDIATE) ? immediate_i : mem_rdata_i;
    // [RULE8] borrow variants use carry, plain ones force no borrow
    assign sub_cin = ((op_code_i == `OP_MINUS_WITH_BORROW_TO_WORK) ||
                      (op_code_i == `OP_MINUS_WITH_BORROW_TO_MEMORY)) ? carry_now : 1'b1;

    rsk_sub_unit u_sub (
        .minuend_i          (work_register_ff),
        .subtrahend_i       (sub_rhs),
        .carry_in_i         (sub_cin),
        .diff_o             (sub_diff),
        .carry_o            (sub_carry),
        .half_borrow_flag_o (sub_half),
        .zero_o             (sub_zero),
        .sign_wrap_flag_o   (sub_wrap)
    );

    assign mem_dec = mem_rdata_i - `BYTE_ONE;
    assign mem_inc = mem_rdata_i + `BYTE_ONE;

    // ========================================
    // operation decode
    always @* begin
        nxt_work_register = work_register_ff;
        nxt_flags         = flags_ff;
        nxt_mem_wdata     = mem_rdata_i;
        nxt_mem_we        = 1'b0;
        nxt_skip          = 1'b0;
        if (issue) begin
            case (op_code_i)
                // [RULE1] rotate left into work
                `OP_ROTATE_LEFT_TO_WORK: begin
                    nxt_work_register = shift_left_fill(mem_rdata_i, mem_rdata_i[7]);
                end
                // [RULE2] left through carry, in place
                `OP_ROTATE_LEFT_THROUGH_BIT: begin
                    nxt_mem_wdata = shift_left_fill(mem_rdata_i, carry_now);
                    nxt_mem_we    = 1'b1;
                    nxt_flags[`FLAG_CARRY_BIT] = mem_rdata_i[7];
                end
                // [RULE3] left through carry, into work
                `OP_ROTATE_LEFT_THROUGH_BIT_WORK: begin
                    nxt_work_register = shift_left_fill(mem_rdata_i, carry_now);
                    nxt_flags[`FLAG_CARRY_BIT] = mem_rdata_i[7];
                end
                // [RULE4] right rotate in place
                `OP_ROTATE_RIGHT_IN_PLACE: begin
                    nxt_mem_wdata = shift_right_fill(mem_rdata_i, mem_rdata_i[0]);
                    nxt_mem_we    = 1'b1;
                end
                // [RULE5] right rotate into work
                `OP_ROTATE_RIGHT_TO_WORK: begin
                    nxt_work_register = shift_right_fill(mem_rdata_i, mem_rdata_i[0]);
                end
                // [RULE6] right through carry, in place
                `OP_ROTATE_RIGHT_THROUGH_BIT: begin
                    nxt_mem_wdata = shift_right_fill(mem_rdata_i, carry_now);
                    nxt_mem_we    = 1'b1;
                    nxt_flags[`FLAG_CARRY_BIT] = mem_rdata_i[0];
                end
                // [RULE7] right through carry, into work
                `OP_ROTATE_RIGHT_THROUGH_BIT_WORK: begin
                    nxt_work_register = shift_right_fill(mem_rdata_i, carry_now);
                    nxt_flags[`FLAG_CARRY_BIT] = mem_rdata_i[0];
                end
                // [RULE8] [RULE10] [RULE12] subtract into work
                `OP_MINUS_WITH_BORROW_TO_WORK, `OP_MINUS_TO_WORK, `OP_MINUS_IMMEDIATE: begin
                    nxt_work_register = sub_diff;
                    nxt_flags = sub_flags(sub_carry, sub_half, sub_zero, sub_wrap);
                end
                // [RULE8] [RULE11] subtract into memory
                `OP_MINUS_WITH_BORROW_TO_MEMORY, `OP_MINUS_TO_MEMORY: begin
                    nxt_mem_wdata = sub_diff;
                    nxt_mem_we    = 1'b1;
                    nxt_flags = sub_flags(sub_carry, sub_half, sub_zero, sub_wrap);
                end
                // [RULE13] decrement in place and skip
                `OP_DEC_SKIP_ON_NULL: begin
                    nxt_mem_wdata = mem_dec;
                    nxt_mem_we    = 1'b1;
                    nxt_skip      = byte_is_null(mem_dec);
                end
                // [RULE14] decrement into work and skip
                `OP_DEC_SKIP_ON_NULL_TO_WORK: begin
                    nxt_work_register = mem_dec;
                    nxt_skip          = byte_is_null(mem_dec);
                end
                // [RULE16] increment in place and skip
                `OP_INC_SKIP_ON_NULL: begin
                    nxt_mem_wdata = mem_inc;
                    nxt_mem_we    = 1'b1;
                    nxt_skip      = byte_is_null(mem_inc);
                end
                // [RULE17] increment into work and skip
                `OP_INC_SKIP_ON_NULL_TO_WORK: begin
                    nxt_work_register = mem_inc;
                    nxt_skip          = byte_is_null(mem_inc);
                end
                // [RULE18] skip on selected bit one
                `OP_BIT_SKIP_IF_ONE: begin
                    nxt_skip = |(mem_rdata_i & bit_mask(bit_sel_i));
                end
                // [RULE19] all ones
                `OP_BYTE_SET: begin
                    nxt_mem_wdata = `BYTE_ALL_ONES;
                    nxt_mem_we    = 1'b1;
                end
                // [RULE20] single bit set
                `OP_BIT_SET: begin
                    nxt_mem_wdata = mem_rdata_i | bit_mask(bit_sel_i);
                    nxt_mem_we    = 1'b1;
                end
                // [RULE21] nibble swap in place
                `OP_NIBBLE_EXCHANGE: begin
                    nxt_mem_wdata = swap_nibbles(mem_rdata_i);
                    nxt_mem_we    = 1'b1;
                end
                // [RULE22] nibble swap into work
                `OP_NIBBLE_EXCHANGE_TO_WORK: begin
                    nxt_work_register = swap_nibbles(mem_rdata_i);
                end
                default: begin
                    nxt_mem_we = 1'b0;
                end
            endcase
        end
    end

    // ========================================
    // skip sequencing
    always @* begin
        case (state_ff)
            // [RULE15] taken skip adds dummy slot
            ST_RUN:   nxt_state = nxt_skip ? ST_DUMMY : ST_RUN;
            ST_DUMMY: nxt_state = ST_RUN;
            default:  nxt_state = ST_RUN;
        endcase
    end

    // ========================================
    // registers
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff         <= ST_RUN;
            work_register_ff <= `WORK_RESET;
            flags_ff         <= `FLAGS_RESET;
            mem_wdata_o      <= 8'h00;
            mem_we_o         <= 1'b0;
            skip_taken_o     <= 1'b0;
        end else begin
            state_ff         <= nxt_state;
            work_register_ff <= nxt_work_register;
            flags_ff         <= nxt_flags;
            mem_wdata_o      <= nxt_mem_wdata;
            mem_we_o         <= nxt_mem_we;
            skip_taken_o     <= nxt_skip;
        end
    end

    assign work_register_o    = work_register_ff;
    assign carry_flag_o       = flags_ff[`FLAG_CARRY_BIT];
    assign half_borrow_flag_o = flags_ff[`FLAG_HALF_BORROW_BIT];
    assign zero_flag_o        = flags_ff[`FLAG_ZERO_BIT];
    assign sign_wrap_flag_o   = flags_ff[`FLAG_SIGN_WRAP_BIT];
    // dummy slot visible to the fetch side
    assign dummy_cycle_o      = (state_ff == ST_DUMMY);

endmodule // rotate_subtract_skip_alu

`default_nettype wire

// file: test/rsk_alu_props.sv
// concurrent checks on the execution unit ports
`timescale 1ns/1ps
`default_nettype none
`include "rsk_alu_regs.vh"
module rsk_alu_props (
    // clock and reset
    input wire logic       core_clk_i,
    input wire logic       reset_n_i,
    // issue
    input wire logic       op_valid_i,
    input wire logic [4:0] op_code_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic       op_ready_o,
    // memory
    input wire logic [7:0] mem_rdata_i,
    input wire logic [7:0] mem_wdata_o,
    input wire logic       mem_we_o,
    // state and skip
    input wire logic [7:0] work_register_o,
    input wire logic       carry_flag_o,
    input wire logic       zero_flag_o,
    input wire logic       skip_taken_o,
    input wire logic       dummy_cycle_o
);
    // ========================================
    // issue capture, so each result is tied to its cause
    logic       take_ff;
    logic [4:0] code_ff;
    logic [7:0] mem_ff;
    logic [7:0] work_ff;
    logic [2:0] sel_ff;
    logic       carry_ff;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            take_ff <= 1'b0;
        end else begin
            take_ff <= op_valid_i && op_ready_o;
        end
    end
    always @(posedge core_clk_i) begin
        code_ff <= op_code_i;
        mem_ff <= mem_rdata_i;
        work_ff <= work_register_o;
        sel_ff <= bit_sel_i;
        carry_ff <= carry_flag_o;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ========================================
    // assertions
    a_rotate_left_work: assert property (
        take_ff && code_ff == `OP_ROTATE_LEFT_TO_WORK |-> !mem_we_o && carry_flag_o == carry_ff
        && work_register_o == {mem_ff[6:0], mem_ff[7]}) else $error("rotate left to work wrong");
    a_left_carry_memory: assert property (
        take_ff && code_ff == `OP_ROTATE_LEFT_THROUGH_BIT |-> mem_we_o && carry_flag_o == mem_ff[7]
        && mem_wdata_o == {mem_ff[6:0], carry_ff}) else $error("rotate left through carry wrong");
    a_right_carry_work: assert property (
        take_ff && code_ff == `OP_ROTATE_RIGHT_THROUGH_BIT_WORK |-> !mem_we_o
        && work_register_o == {carry_ff, mem_ff[7:1]} && carry_flag_o == mem_ff[0])
        else $error("rotate right through carry to work wrong");
    a_minus_work: assert property (
        take_ff && code_ff == `OP_MINUS_TO_WORK |-> work_register_o == work_ff - mem_ff
        && carry_flag_o == (work_ff >= mem_ff) && zero_flag_o == (work_ff == mem_ff))
        else $error("plain subtract wrong");
    a_dec_skip: assert property (
        take_ff && code_ff == `OP_DEC_SKIP_ON_NULL |-> mem_we_o && mem_wdata_o == mem_ff - 8'h01
        && skip_taken_o == (mem_ff == 8'h01)) else $error("decrement skip wrong");
    a_bit_test: assert property (
        take_ff && code_ff == `OP_BIT_SKIP_IF_ONE |-> !mem_we_o
        && skip_taken_o == mem_ff[sel_ff]) else $error("bit skip wrong");
    a_byte_set: assert property (
        take_ff && code_ff == `OP_BYTE_SET |-> mem_we_o && mem_wdata_o == 8'hff)
        else $error("byte set wrong");
    a_skip_dummy: assert property (
        skip_taken_o |-> dummy_cycle_o && !op_ready_o ##1 !dummy_cycle_o && op_ready_o)
        else $error("dummy cycle wrong");
    a_refused_issue: assert property (
        dummy_cycle_o |=> !mem_we_o && !skip_taken_o && $stable(work_register_o))
        else $error("issue during dummy cycle acted");
    a_nibble_work: assert property (
        take_ff && code_ff == `OP_NIBBLE_EXCHANGE_TO_WORK |-> !mem_we_o
        && work_register_o == {mem_ff[3:0], mem_ff[7:4]}) else $error("nibble swap to work wrong");
    a_bit_set: assert property (
        take_ff && code_ff == `OP_BIT_SET |-> mem_we_o
        && mem_wdata_o == (mem_ff | (8'h01 << sel_ff))) else $error("bit set wrong");
endmodule // rsk_alu_props
bind rotate_subtract_skip_alu rsk_alu_props props_u (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .bit_sel_i(bit_sel_i), .op_ready_o(op_ready_o),
    .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
    .work_register_o(work_register_o), .carry_flag_o(carry_flag_o),
    .zero_flag_o(zero_flag_o), .skip_taken_o(skip_taken_o), .dummy_cycle_o(dummy_cycle_o));
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the rotate, subtract and skip execution unit
`timescale 1ns/1ps
`default_nettype none
`include "rsk_alu_regs.vh"
module testbench;
    // ========================================
    // stimulus, outputs and expected state
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       valid = 1'b0;
    logic [4:0] code = 5'h00;
    logic [2:0] sel = 3'h0;
    logic [7:0] imm = 8'h00;
    logic [7:0] mem = 8'h00;
    wire        ready, we, skip, dummy, c_o, h_o, z_o, v_o;
    wire  [7:0] wdata, work;
    integer     failures = 0;
    integer     samples_checked = 0;
    integer     seed = 52;
    integer     i;
    logic [31:0] r;
    logic [7:0] e_work = 8'h00;
    logic [3:0] e_flags = 4'h0;
    logic [7:0] e_wd;
    logic       e_we, e_skip;
    always #25 clk = ~clk;
    rotate_subtract_skip_alu dut_u (
        .core_clk_i(clk), .reset_n_i(rst_n), .op_valid_i(valid), .op_code_i(code),
        .bit_sel_i(sel), .immediate_i(imm), .op_ready_o(ready), .mem_rdata_i(mem),
        .mem_wdata_o(wdata), .mem_we_o(we), .work_register_o(work), .carry_flag_o(c_o),
        .half_borrow_flag_o(h_o), .zero_flag_o(z_o), .sign_wrap_flag_o(v_o),
        .skip_taken_o(skip), .dummy_cycle_o(dummy));
    // ========================================
    // comparison, model and issue
    task check(input logic [11:0] seen, input logic [11:0] exp);
        begin
            samples_checked++;
            if (seen !== exp) begin
                failures++;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // returns {wrap, zero, half, carry, result}; carry is an inverted borrow
    function automatic [11:0] sub_model(input [7:0] a, input [7:0] b, input cin);
        logic [8:0] d;
        logic [4:0] n;
        begin
            d = {1'b0, a} - {1'b0, b} - {8'h00, ~cin};
            n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
            sub_model = {(a[7] ^ b[7]) & (d[7] ^ a[7]), d[7:0] == 8'h00, ~n[4], ~d[8], d[7:0]};
        end
    endfunction
    task automatic model(input [4:0] op, input [7:0] m, input [2:0] b, input [7:0] x);
        logic c;
        begin
            c = e_flags[0];
            {e_we, e_wd, e_skip} = 10'h000;
            case (op)
                `OP_ROTATE_LEFT_TO_WORK: e_work = {m[6:0], m[7]};
                `OP_ROTATE_LEFT_THROUGH_BIT: {e_we, e_wd, e_flags[0]} = {1'b1, m[6:0], c, m[7]};
                `OP_ROTATE_LEFT_THROUGH_BIT_WORK: {e_work, e_flags[0]} = {m[6:0], c, m[7]};
                `OP_ROTATE_RIGHT_IN_PLACE: {e_we, e_wd} = {1'b1, m[0], m[7:1]};
                `OP_ROTATE_RIGHT_TO_WORK: e_work = {m[0], m[7:1]};
                `OP_ROTATE_RIGHT_THROUGH_BIT: {e_we, e_wd, e_flags[0]} = {1'b1, c, m[7:1], m[0]};
                `OP_ROTATE_RIGHT_THROUGH_BIT_WORK: {e_work, e_flags[0]} = {c, m[7:1], m[0]};
                `OP_MINUS_WITH_BORROW_TO_WORK: {e_flags, e_work} = sub_model(e_work, m, c);
                `OP_MINUS_WITH_BORROW_TO_MEMORY:
                    {e_we, e_flags, e_wd} = {1'b1, sub_model(e_work, m, c)};
                `OP_MINUS_TO_WORK: {e_flags, e_work} = sub_model(e_work, m, 1'b1);
                `OP_MINUS_TO_MEMORY: {e_we, e_flags, e_wd} = {1'b1, sub_model(e_work, m, 1'b1)};
                `OP_MINUS_IMMEDIATE: {e_flags, e_work} = sub_model(e_work, x, 1'b1);
                `OP_DEC_SKIP_ON_NULL: {e_we, e_wd, e_skip} = {1'b1, m - 8'h01, m == 8'h01};
                `OP_DEC_SKIP_ON_NULL_TO_WORK: {e_work, e_skip} = {m - 8'h01, m == 8'h01};
                `OP_INC_SKIP_ON_NULL: {e_we, e_wd, e_skip} = {1'b1, m + 8'h01, m == 8'hff};
                `OP_INC_SKIP_ON_NULL_TO_WORK: {e_work, e_skip} = {m + 8'h01, m == 8'hff};
                `OP_BIT_SKIP_IF_ONE: e_skip = m[b];
                `OP_BYTE_SET: {e_we, e_wd} = {1'b1, 8'hff};
                `OP_BIT_SET: {e_we, e_wd} = {1'b1, m | (8'h01 << b)};
                `OP_NIBBLE_EXCHANGE: {e_we, e_wd} = {1'b1, m[3:0], m[7:4]};
                `OP_NIBBLE_EXCHANGE_TO_WORK: e_work = {m[3:0], m[7:4]};
                default: ;
            endcase
        end
    endtask
    task automatic run_op(input [4:0] op, input [7:0] m, input [2:0] b, input [7:0] x);
        begin
            @(posedge clk);
            valid <= 1'b1;
            code <= op;
            mem <= m;
            sel <= b;
            imm <= x;
            model(op, m, b, x);
            @(posedge clk);
            // an issue offered in the dummy slot must be refused
            valid <= e_skip;
            code <= `OP_BYTE_SET;
            #1;
            check({4'h0, work}, {4'h0, e_work});
            check({8'h00, v_o, z_o, h_o, c_o}, {8'h00, e_flags});
            check({11'h000, we}, {11'h000, e_we});
            if (e_we) check({4'h0, wdata}, {4'h0, e_wd});
            check({9'h000, skip, dummy, ready}, {9'h000, e_skip, e_skip, ~e_skip});
            if (e_skip) begin
                @(posedge clk);
                valid <= 1'b0;
                #1;
                check({3'h0, we, work}, {4'h0, e_work});
            end
        end
    endtask
    task summarize;
        begin
            $display("compares %0d mismatches %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // ========================================
    // tests
    initial begin
        #400000;
        failures++;
        summarize;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 32; i++) begin
            r = $random(seed);
            run_op(i[4:0], r[7:0], r[10:8], r[23:16]);
        end
        $display("code sweep done");
        for (i = 0; i < 300; i++) begin
            r = $random(seed);
            run_op(r[28:24], r[7:0], r[10:8], r[23:16]);
        end
        $display("random ops done");
        run_op(`OP_DEC_SKIP_ON_NULL, 8'h01, 3'h0, 8'h00);
        run_op(`OP_INC_SKIP_ON_NULL_TO_WORK, 8'hff, 3'h0, 8'h00);
        run_op(`OP_BIT_SKIP_IF_ONE, 8'h80, 3'h7, 8'h00);
        run_op(`OP_MINUS_IMMEDIATE, 8'h00, 3'h0, e_work);
        run_op(`OP_ROTATE_LEFT_TO_WORK, 8'hbf, 3'h0, 8'h00);
        // signed wrap and borrow out, then borrow consumed down to zero
        run_op(`OP_MINUS_TO_WORK, 8'h80, 3'h0, 8'h00);
        run_op(`OP_MINUS_WITH_BORROW_TO_MEMORY, 8'hfe, 3'h0, 8'h00);
        $display("corner cases done");
        summarize;
    end
endmodule // testbench
`default_nettype wire
